// *** src/psc_pkg.sv ***
// Package for the PWM submodule control block: register map, fields, constants
`default_nettype none
package psc_pkg;
   // Word byte addresses on the Avalon-MM slave
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_PERIOD = 4'h4;
   localparam logic [3:0] ADDR_WIDTH  = 4'h8;
   localparam logic [3:0] ADDR_COUNT  = 4'hC;
   // Control/status field positions
   localparam int FLAG_BIT = 15;
   localparam int PIN_BIT  = 7;
   localparam int LOAD_BIT = 5;
   localparam int POL_BIT  = 4;
   localparam int RUN_BIT  = 3;
   localparam int CLK_LSB  = 0;
   localparam int DIV3_BIT = 8;
   // Reset values
   localparam logic [15:0] CTRL_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_START = 16'h0001;
   localparam logic [15:0] DATA_RESET  = 16'h0000;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
   // Divider figures
   localparam logic [1:0] PRE1_DIV2 = 2'h1;
   localparam logic [1:0] PRE1_DIV3 = 2'h2;
   localparam int         PRE2_W    = 8;

   typedef struct packed {
      logic       output_polarity;
      logic       run;
      logic [2:0] clk_sel;
      logic       div3;
   } psc_ctrl_t;
endpackage : psc_pkg
`default_nettype wire

// *** src/psc_top.sv ***
// PWM submodule control: Avalon-MM registers, prescaler, counter, comparators, output pin
//
// Functional notes
// - Polarity bit 4 selects true or inverted output flip-flop drive on the pin.
// - Run bit 3 low: flip-flop held reset, pin low or high per polarity.
// - Divide-by-256 prescaler held in reset while disabled.
// - Counter stops and is held at 0x0001 while disabled.
// - Comparators give no matches while disabled.
// - Staging period and width copied every cycle into active buffers while disabled.
// - Run bit rising sets the output flip-flop to start the first pulse.
// - On enable, prescaler released and counter counts from 0x0001.
// - Run bit rising sets the period-complete flag.
// - Enabled: continuous PWM from active buffers, reloaded at each period end.
// - Clock select bits 2:0 pick one of eight rates, changeable anytime.
// - Divide-by-three clear: codes give /2,/4,/8,/16,/32,/64,/128 and /512.
// - Divide-by-three set: codes give /3,/6,/12,/24,/48,/96,/192 and /768.
// - Polarity zero gives high pulses; polarity one inverts all edges.
// - Flag sets at each period end and stays until software clears it or the run bit goes low.
// - Staging period moves to active period at end of current period.
`default_nettype none
module psc_top
   import psc_pkg::*;
#(
   parameter int DATA_W = 16
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // PWM output pin
   output logic             pwm_out
);
   import psc_pkg::*;

   // Lane merge and read mux are built for 16-bit registers only
   if (DATA_W != 16) begin : g_bad_width
      $error("psc_top: DATA_W must be 16");
   end

   // Software-visible state
   psc_ctrl_t         ctrl, next_ctrl;
   logic              flag, next_flag;
   logic              flag_seen, next_flag_seen;
   logic [15:0]       period_staging, next_period_staging;
   logic [15:0]       width_staging, next_width_staging;

   // Datapath state
   logic [15:0]       period_active, next_period_active;
   logic [15:0]       width_active, next_width_active;
   logic [15:0]       count, next_count;
   logic              out_ff, next_out_ff;
   logic              run_d, next_run_d;
   logic [1:0]        pre1, next_pre1;
   logic [PRE2_W-1:0] pre2, next_pre2;

   // Bus answer and decode
   logic [31:0]       next_readdata;
   logic              ack, next_ack;
   logic              first_tick, tick;
   logic              wr_ctrl, load_req, run_rise, period_end, width_hit;

   // Single-cycle wait state: request answered on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction

   // Merge the enabled byte lanes of a write into a 16-bit register
   function automatic logic [15:0] lane_merge(input logic [15:0] old_val, input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [15:0] m;
      m = old_val;
      if (be[0])
         m[7:0] = wd[7:0];
      if (be[1])
         m[15:8] = wd[15:8];
      lane_merge = m;
   endfunction

   assign wr_ctrl  = avs_write & ~ack & hit(avs_address, ADDR_CTRL) & avs_byteenable[0];
   assign load_req = wr_ctrl & avs_writedata[LOAD_BIT];
   assign run_rise = ctrl.run & ~run_d;

   // First stage divides by two or three; second stage is the /256 chain
   // Held at zero while stopped so the first tick after enable is a full one
   always_comb begin
      next_pre1 = 2'h0;
      if (ctrl.run && !(pre1 == (ctrl.div3 ? PRE1_DIV3 : PRE1_DIV2)))
         next_pre1 = pre1 + 2'h1;
      first_tick = ctrl.run && (pre1 == (ctrl.div3 ? PRE1_DIV3 : PRE1_DIV2));
      next_pre2 = '0;
      if (ctrl.run)
         next_pre2 = first_tick ? pre2 + 8'h01 : pre2;
   end

   // Low chain bits that must all be one for a tick at this select code
   function automatic logic [PRE2_W-1:0] stage_mask(input logic [2:0] sel);
      logic [PRE2_W-1:0] m;
      m = '0;
      case (sel)
         3'h0:    m = 8'h00;
         3'h1:    m = 8'h01;
         3'h2:    m = 8'h03;
         3'h3:    m = 8'h07;
         3'h4:    m = 8'h0F;
         3'h5:    m = 8'h1F;
         3'h6:    m = 8'h3F;
         3'h7:    m = 8'hFF;
         default: m = 8'h00;
      endcase
      stage_mask = m;
   endfunction

   // Tick when the selected stage of the chain rolls over
   always_comb begin
      tick = 1'b0;
      if (first_tick)
         tick = ((pre2 & stage_mask(ctrl.clk_sel)) == stage_mask(ctrl.clk_sel));
   end

   // Comparators only look while running
   // Period ends on the tick that finds the count at or above the active period
   assign period_end = ctrl.run && !run_rise && tick && (count >= period_active);
   assign width_hit  = ctrl.run && !run_rise && tick && (count + 16'h0001 == width_active);

   always_comb begin
      next_count         = count;
      next_out_ff        = out_ff;
      next_period_active = period_active;
      next_width_active  = width_active;
      if (!ctrl.run) begin
         next_count         = COUNT_START;
         next_out_ff        = 1'b0;
         next_period_active = period_staging;
         next_width_active  = width_staging;
      end else if (load_req) begin
         // Fresh period start without waiting for a tick
         next_period_active = period_staging;
         next_width_active  = width_staging;
         next_count         = COUNT_START;
         next_out_ff        = (width_staging != DATA_RESET);
      end else if (run_rise) begin
         next_count  = COUNT_START;
         next_out_ff = 1'b1;
      end else if (period_end) begin
         // Zero width keeps the flip-flop clear for the whole period
         next_period_active = period_staging;
         next_width_active  = width_staging;
         next_count         = COUNT_START;
         next_out_ff        = (width_staging != DATA_RESET);
      end else if (tick) begin
         next_count = count + 16'h0001;
         if (width_hit)
            next_out_ff = 1'b0;
      end
   end

   // Control register: run, polarity, rate select
   always_comb begin
      next_ctrl  = ctrl;
      next_run_d = ctrl.run;
      if (wr_ctrl) begin
         next_ctrl.output_polarity     = avs_writedata[POL_BIT];
         next_ctrl.run     = avs_writedata[RUN_BIT];
         next_ctrl.clk_sel = avs_writedata[CLK_LSB +: 3];
      end
      if (avs_write && !ack && hit(avs_address, ADDR_CTRL) && avs_byteenable[1])
         next_ctrl.div3 = avs_writedata[DIV3_BIT];
   end

   // Staging registers take byte lanes at any time, running or not
   always_comb begin
      next_period_staging = period_staging;
      next_width_staging  = width_staging;
      if (avs_write && !ack && hit(avs_address, ADDR_PERIOD))
         next_period_staging = lane_merge(period_staging, avs_writedata, avs_byteenable);
      if (avs_write && !ack && hit(avs_address, ADDR_WIDTH))
         next_width_staging = lane_merge(width_staging, avs_writedata, avs_byteenable);
   end

   // Flag: set by hardware, cleared by read-one then write-zero
   always_comb begin
      next_flag      = flag;
      next_flag_seen = flag_seen;
      // Clear needs a prior read of one; any set in between cancels it
      if (avs_write && !ack && hit(avs_address, ADDR_CTRL) && avs_byteenable[1]
          && !avs_writedata[FLAG_BIT] && flag_seen)
         next_flag = 1'b0;
      if (avs_read && !ack && hit(avs_address, ADDR_CTRL) && flag)
         next_flag_seen = 1'b1;
      if (avs_write && !ack && hit(avs_address, ADDR_CTRL))
         next_flag_seen = 1'b0;
      // Disabled: cleared and held
      if (!ctrl.run)
         next_flag = 1'b0;
      // Hardware set wins over a clear in the same cycle
      if (run_rise || period_end || load_req) begin
         next_flag      = 1'b1;
         next_flag_seen = 1'b0;
      end
   end

   // Bus answer: one wait state, read data held until the next read
   always_comb begin
      next_ack      = (avs_read | avs_write) & ~ack;
      next_readdata = avs_readdata;
      if (avs_read && !ack) begin
         case (avs_address)
            ADDR_CTRL:   next_readdata = {16'h0000, flag, 6'h00, ctrl.div3, pwm_out, 2'h0,
                                          ctrl.output_polarity, ctrl.run, ctrl.clk_sel};
            ADDR_PERIOD: next_readdata = {16'h0000, period_staging};
            ADDR_WIDTH:  next_readdata = {16'h0000, width_staging};
            ADDR_COUNT:  next_readdata = {16'h0000, count};
            default:     next_readdata = UNMAPPED_RD;
         endcase
      end
   end

   // Bus answer registers
   // Read data stands until the first edge of the next read
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         avs_readdata <= UNMAPPED_RD;
         ack          <= 1'b0;
      end else begin
         avs_readdata <= next_readdata;
         ack          <= next_ack;
      end
   end

   // Control register and its edge detector
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ctrl  <= psc_ctrl_t'(6'h00);
         run_d <= 1'b0;
      end else begin
         ctrl  <= next_ctrl;
         run_d <= next_run_d;
      end
   end

   // Staging registers
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         period_staging <= DATA_RESET;
         width_staging  <= DATA_RESET;
      end else begin
         period_staging <= next_period_staging;
         width_staging  <= next_width_staging;
      end
   end

   // Period-complete flag and its read-one record
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flag      <= 1'b0;
         flag_seen <= 1'b0;
      end else begin
         flag      <= next_flag;
         flag_seen <= next_flag_seen;
      end
   end

   // Prescaler chain
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pre1 <= 2'h0;
         pre2 <= '0;
      end else begin
         pre1 <= next_pre1;
         pre2 <= next_pre2;
      end
   end

   // Counter, active buffers, output flip-flop and pin
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         count         <= COUNT_START;
         out_ff        <= 1'b0;
         period_active <= DATA_RESET;
         width_active  <= DATA_RESET;
         pwm_out       <= 1'b0;
      end else begin
         count         <= next_count;
         out_ff        <= next_out_ff;
         period_active <= next_period_active;
         width_active  <= next_width_active;
         // Pin goes idle on the same edge that clears run
         pwm_out       <= (next_ctrl.run & next_out_ff) ^ next_ctrl.output_polarity;
      end
   end
endmodule // psc_top
`default_nettype wire

// *** verification/psc_load.sv ***
// Load model on the PWM pin: measures period and high time
`default_nettype none
module psc_load (
   // Clock and pin
   input wire logic sys_clk,
   input wire logic pwm_out,
   // Measurements in clock cycles
   output int       rises,
   output int       period,
   output int       high
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   bit last;
   // Rise to rise is the periodic edge at polarity zero
   always @(posedge sys_clk) begin
      last <= pwm_out;
      cnt <= cnt + 1;
      if (pwm_out && !last) begin
         rises <= rises + 1;
         period <= cnt;
         cnt <= 1;
      end
      if (!pwm_out && last) begin
         high <= cnt;
      end
   end
endmodule // psc_load
`default_nettype wire

// *** verification/psc_properties.sv ***
// Concurrent checks on the PWM submodule control ports
`default_nettype none
module psc_properties
   import psc_pkg::*;
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        srst,
   // Register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Pin
   input wire logic        pwm_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run_s, pol_s, next_run_s, next_pol_s, done;
   assign done = !avs_waitrequest && (avs_read || avs_write);
   // Shadow lands on the first edge of a write, the edge the design acts on
   always_comb begin
      next_run_s = run_s;
      next_pol_s = pol_s;
      if (avs_write && avs_waitrequest && avs_address == ADDR_CTRL && avs_byteenable[0]) begin
         next_run_s = avs_writedata[RUN_BIT];
         next_pol_s = avs_writedata[POL_BIT];
      end
   end
   always_ff @(posedge sys_clk) begin
      run_s <= srst ? 1'b0 : next_run_s;
      pol_s <= srst ? 1'b0 : next_pol_s;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_req_open; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_idle_rd(logic [3:0] a); avs_read && done && avs_address == a && !run_s; endsequence
   property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait state on new request");
   property p_wait_answer; s_req_open |=> !avs_waitrequest; endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("answer not in second cycle");
   property p_rd_upper; avs_read && done |-> avs_readdata[31:16] == 16'h0000; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");
   property p_rd_stand; $changed(avs_readdata) |-> avs_read; endproperty
   a_rd_stand: assert property (p_rd_stand) else $error("read data moved without read");
   property p_unmapped; avs_read && done && avs_address[1:0] != 2'h0 |-> avs_readdata == UNMAPPED_RD; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_idle_pin; !run_s |-> pwm_out == pol_s; endproperty
   a_idle_pin: assert property (p_idle_pin) else $error("idle pin not at polarity");
   property p_cnt_hold; s_idle_rd(ADDR_COUNT) |-> avs_readdata == {16'h0000, COUNT_START}; endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counter not held at one");
   property p_flag_idle; s_idle_rd(ADDR_CTRL) |-> !avs_readdata[FLAG_BIT]; endproperty
   a_flag_idle: assert property (p_flag_idle) else $error("flag set while disabled");
endmodule // psc_properties
`default_nettype wire

// *** verification/tb_psc_top.sv ***
// Testbench for the PWM submodule control block
`default_nettype none
module tb_psc_top import psc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, pwm_out;
   logic [3:0]  avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
   int          rises, period, high, hold, base, bad_count, n_tests;
   int          divs [16] = '{2, 4, 8, 16, 32, 64, 128, 512, 3, 6, 12, 24, 48, 96, 192, 768};
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
   psc_top u_psc_top (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out));
   psc_load u_psc_load (.sys_clk(sys_clk), .pwm_out(pwm_out), .rises(rises), .period(period), .high(high));
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Sweep of all rates needs about 25k cycles
   initial begin
      repeat (50000) @(posedge sys_clk);
      bad_count++;
      report_and_stop();
   end
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wait_rises(input int n);
      base = rises;
      while (rises < base + n) @(posedge sys_clk);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      bus(1'b0, ADDR_CTRL, 32'h0);
      `CHK("ctrl", {16'h0000, CTRL_RESET}, rdv)
      bus(1'b1, ADDR_COUNT, 32'h55);
      bus(1'b0, ADDR_COUNT, 32'h0);
      `CHK("count", {16'h0000, COUNT_START}, rdv)
      bus(1'b0, 4'h2, 32'h0);
      `CHK("unmapped", UNMAPPED_RD, rdv)
      bus(1'b1, ADDR_CTRL, 32'h10);
      @(negedge sys_clk);
      `CHK("idle pin", 1'b1, pwm_out)
      bus(1'b1, ADDR_CTRL, 32'h0);
      bus(1'b1, ADDR_PERIOD, 32'h4);
      bus(1'b1, ADDR_WIDTH, 32'h2);
      $display("test registers done");
      bus(1'b1, ADDR_CTRL, 32'h8);
      @(negedge sys_clk);
      `CHK("first pulse", 1'b1, pwm_out)
      bus(1'b0, ADDR_CTRL, 32'h0);
      `CHK("flag", 1'b1, rdv[FLAG_BIT])
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, ADDR_CTRL, {23'h0, i[3], 5'h01, i[2:0]});
         wait_rises(3);
         if (i == 0) hold = high;
         `CHK("period", 4 * divs[i], period)
      end
      bus(1'b1, ADDR_CTRL, 32'h18);
      wait_rises(3);
      `CHK("inverted high", 8 - hold, high)
      bus(1'b1, ADDR_CTRL, 32'h8);
      bus(1'b1, ADDR_PERIOD, 32'h6);
      wait_rises(3);
      `CHK("reloaded period", 12, period)
      $display("test waveform done");
      bus(1'b1, ADDR_WIDTH, 32'h0);
      repeat (24) @(posedge sys_clk);
      bus(1'b1, ADDR_CTRL, 32'h0);
      bus(1'b0, ADDR_COUNT, 32'h0);
      `CHK("stopped count", {16'h0000, COUNT_START}, rdv)
      @(negedge sys_clk);
      `CHK("stopped pin", 1'b0, pwm_out)
      bus(1'b1, ADDR_PERIOD, 32'h3);
      bus(1'b1, ADDR_WIDTH, 32'h2);
      bus(1'b1, ADDR_CTRL, 32'h8);
      wait_rises(3);
      `CHK("tracked period", 6, period)
      $display("test restart done");
      report_and_stop();
   end
endmodule // tb_psc_top
bind psc_top psc_properties u_psc_properties (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out));
`default_nettype wire
